/* design/pin_override_consts.svh */
// Constants of the port alternate-function override block.
// Assumes inclusion by bare name from design files only.
`ifndef PIN_OVERRIDE_CONSTS_SVH
`define PIN_OVERRIDE_CONSTS_SVH

// ************************************************
// Pin indices in the flattened override vectors
// ************************************************
`define PIN_B0 0
`define PIN_B1 1
`define PIN_B2 2
`define PIN_B3 3
`define PIN_B4 4
`define PIN_B5 5
`define PIN_B6 6
`define PIN_B7 7
`define PIN_C4 8
`define PIN_C5 9
`define PIN_C6 10

// ************************************************
// Reset values
// ************************************************
`define PAD_SYNC_RST  11'h7FF
`define TW_RST        2'h3
`define OUT_RST       1'b0

// ************************************************
// Timing
// ************************************************
`define CLK_PERIOD_NS 40
`define SPIKE_NS      50
`define SPIKE_CYCLES  ((`SPIKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* design/pin_override_pkg.sv */
// Types shared by the port alternate-function override block.
// Assumes nothing of its surroundings.
package pin_override_pkg;
   typedef logic [7:0]  port_b_type;
   typedef logic [6:4]  port_c_type;
   typedef logic [10:0] pin_vec_type;
   typedef logic [1:0]  spike_cnt_type;
endpackage

/* design/pin_override_cell.sv */
// One pin: chooses register or peripheral value per attribute.
// Assumes the caller registers the results.
`timescale 1ns/100ps
`default_nettype none
module pin_override_cell
(
   // Port register bits
   input  wire logic i_port_out,
   input  wire logic i_port_dir,
   input  wire logic i_pullup_disable,
   input  wire logic i_sleeping,
   // Override pairs
   input  wire logic i_pullup_override_en,
   input  wire logic i_pullup_override_val,
   input  wire logic i_direction_override_en,
   input  wire logic i_direction_override_val,
   input  wire logic i_port_value_override_en,
   input  wire logic i_port_value_override_val,
   input  wire logic i_input_enable_override_en,
   input  wire logic i_input_enable_override_val,
   // Resolved pin attributes
   output logic      o_pullup,
   output logic      o_oe,
   output logic      o_out,
   output logic      o_in_en
);
   // ************************************************
   // Attribute selection
   // ************************************************
   always_comb
   begin
      o_pullup = i_pullup_override_en ? i_pullup_override_val
                                      : (i_port_out & ~i_port_dir & ~i_pullup_disable);
      o_oe     = i_direction_override_en ? i_direction_override_val : i_port_dir;
      o_out    = i_port_value_override_en ? i_port_value_override_val : i_port_out;
      o_in_en  = i_input_enable_override_en ? i_input_enable_override_val : ~i_sleeping;
   end
endmodule
`default_nettype wire

/* design/port_alternate_function_override.sv */
// Top of the port alternate-function override block for Port B and
// Port C pins 4..6: registered pad controls and peripheral inputs.
// Assumes peripheral controls come from logic on i_clk; pads are async.
`timescale 1ns/100ps
`default_nettype none
`include "pin_override_consts.svh"
module port_alternate_function_override
(
   // Clock and reset
   input  wire logic                           i_clk,
   input  wire logic                           i_reset_n,
   // Port registers
   input  wire pin_override_pkg::port_b_type   i_port_out_b,
   input  wire pin_override_pkg::port_b_type   i_port_dir_b,
   input  wire pin_override_pkg::port_c_type   i_port_out_c,
   input  wire pin_override_pkg::port_c_type   i_port_dir_c,
   input  wire logic                           i_global_pullup_disable,
   input  wire logic                           i_sleeping,
   // SPI
   input  wire logic                           i_serial_periph_enable_bit,
   input  wire logic                           i_serial_periph_master_sel,
   input  wire logic                           i_spi_sck_out,
   input  wire logic                           i_spi_master_data_out,
   input  wire logic                           i_spi_slave_data_out,
   // Timers
   input  wire logic                           i_timer1_compare_a_en,
   input  wire logic                           i_timer1_compare_a_out,
   input  wire logic                           i_timer1_compare_b_en,
   input  wire logic                           i_timer1_compare_b_out,
   input  wire logic                           i_timer2_compare_a_en,
   input  wire logic                           i_timer2_compare_a_out,
   // Clock system and fuses
   input  wire logic                           i_clock_output_fuse,
   input  wire logic                           i_divided_sysclk_out,
   input  wire logic                           i_internal_rc_selected,
   input  wire logic                           i_external_clock_selected,
   input  wire logic                           i_timer2_async_select,
   input  wire logic                           i_reset_pin_disable_fuse,
   // Two-wire
   input  wire logic                           i_twowire_enable_bit,
   input  wire logic                           i_twowire_scl_drive_low,
   input  wire logic                           i_twowire_sda_drive_low,
   // Pin change
   input  wire pin_override_pkg::port_b_type   i_pin_change_mask_b,
   input  wire pin_override_pkg::port_c_type   i_pin_change_mask_c,
   input  wire logic                           i_pin_change_group0_enable,
   input  wire logic                           i_pin_change_group1_enable,
   // Pads in
   input  wire pin_override_pkg::port_b_type   i_pad_b,
   input  wire pin_override_pkg::port_c_type   i_pad_c,
   // Pads out
   output logic [7:1]                          o_pad_b_out,
   output logic [7:1]                          o_pad_b_oe,
   output logic                                o_pad_b0_out,
   output logic                                o_pad_b0_oe,
   output pin_override_pkg::port_b_type        o_pad_b_pullup,
   output pin_override_pkg::port_c_type        o_pad_c_out,
   output pin_override_pkg::port_c_type        o_pad_c_oe,
   output pin_override_pkg::port_c_type        o_pad_c_pullup,
   // Register readback
   output pin_override_pkg::port_b_type        o_pin_in_b,
   output pin_override_pkg::port_c_type        o_pin_in_c,
   output logic                                o_dir_read_c6,
   output logic                                o_out_read_c6,
   // Peripheral inputs
   output logic                                o_timer1_capture_in,
   output logic                                o_spi_slave_select_n,
   output logic                                o_spi_slave_active,
   output logic                                o_spi_master_data_in,
   output logic                                o_spi_slave_data_in,
   output logic                                o_spi_sck_in,
   output logic                                o_twowire_scl_in,
   output logic                                o_twowire_sda_in,
   output logic                                o_ext_reset_n
);
   import pin_override_pkg::*;

   pin_vec_type   pullup_override_en, pullup_override_val, direction_override_en, direction_override_val, port_value_override_en, port_value_override_val, input_enable_override_en, input_enable_override_val;
   pin_vec_type   pin_pullup, pin_oe, pin_out, pin_in_en;
   pin_vec_type   port_out_all, port_dir_all, pad_all;
   pin_vec_type   sync1_q, sync2_q, sync3_q, stab_q;
   logic [1:0]    tw_q;
   spike_cnt_type tw_cnt_q [2];
   logic          slave, master, rst_pin, osc_in_own, osc_out_own;

   assign port_out_all = {i_port_out_c, i_port_out_b};
   assign port_dir_all = {i_port_dir_c, i_port_dir_b};
   assign pad_all      = {i_pad_c, i_pad_b};

   function automatic logic pullup_if_input(input logic port_bit);
      pullup_if_input = port_bit & ~i_global_pullup_disable;
   endfunction

   // ************************************************
   // Override equations
   // ************************************************
   always_comb
   begin
      slave       = i_serial_periph_enable_bit & ~i_serial_periph_master_sel;
      master      = i_serial_periph_enable_bit & i_serial_periph_master_sel;
      rst_pin     = ~i_reset_pin_disable_fuse;
      osc_in_own  = ~i_internal_rc_selected | i_timer2_async_select;
      osc_out_own = (~i_internal_rc_selected & ~i_external_clock_selected)
                    | i_timer2_async_select;
      pullup_override_en  = '0;
      pullup_override_val  = '0;
      direction_override_en  = '0;
      direction_override_val  = '0;
      port_value_override_en  = '0;
      port_value_override_val  = '0;
      input_enable_override_en = {i_pin_change_mask_c & {3{i_pin_change_group1_enable}},
               i_pin_change_mask_b & {8{i_pin_change_group0_enable}}};
      input_enable_override_val = '1;
      // Pin 0: divided clock out
      direction_override_en[`PIN_B0] = i_clock_output_fuse;
      direction_override_val[`PIN_B0] = 1'b1;
      port_value_override_en[`PIN_B0] = i_clock_output_fuse;
      port_value_override_val[`PIN_B0] = i_divided_sysclk_out;
      // Pin 1: compare A
      port_value_override_en[`PIN_B1] = i_timer1_compare_a_en;
      port_value_override_val[`PIN_B1] = i_timer1_compare_a_out;
      // Pin 2: slave select and compare B
      pullup_override_en[`PIN_B2] = slave;
      pullup_override_val[`PIN_B2] = pullup_if_input(i_port_out_b[2]);
      direction_override_en[`PIN_B2] = slave;
      port_value_override_en[`PIN_B2] = i_timer1_compare_b_en;
      port_value_override_val[`PIN_B2] = i_timer1_compare_b_out;
      // Pin 3: MOSI and timer2 compare A
      pullup_override_en[`PIN_B3] = slave;
      pullup_override_val[`PIN_B3] = pullup_if_input(i_port_out_b[3]);
      direction_override_en[`PIN_B3] = slave;
      port_value_override_en[`PIN_B3] = master | i_timer2_compare_a_en;
      port_value_override_val[`PIN_B3] = (master & i_spi_master_data_out)
                      | (i_timer2_compare_a_en & i_timer2_compare_a_out);
      // Pin 4: MISO
      pullup_override_en[`PIN_B4] = master;
      pullup_override_val[`PIN_B4] = pullup_if_input(i_port_out_b[4]);
      direction_override_en[`PIN_B4] = master;
      port_value_override_en[`PIN_B4] = slave;
      port_value_override_val[`PIN_B4] = i_spi_slave_data_out;
      // Pin 5: SCK
      pullup_override_en[`PIN_B5] = slave;
      pullup_override_val[`PIN_B5] = pullup_if_input(i_port_out_b[5]);
      direction_override_en[`PIN_B5] = slave;
      port_value_override_en[`PIN_B5] = master;
      port_value_override_val[`PIN_B5] = i_spi_sck_out;
      // Pins 6 and 7: oscillator
      pullup_override_en[`PIN_B6]  = osc_in_own;
      direction_override_en[`PIN_B6]  = osc_in_own;
      input_enable_override_en[`PIN_B6] = osc_in_own | input_enable_override_en[`PIN_B6];
      input_enable_override_val[`PIN_B6] = i_internal_rc_selected & ~i_timer2_async_select;
      pullup_override_en[`PIN_B7]  = osc_out_own;
      direction_override_en[`PIN_B7]  = osc_out_own;
      input_enable_override_en[`PIN_B7] = osc_out_own | input_enable_override_en[`PIN_B7];
      input_enable_override_val[`PIN_B7] = (i_internal_rc_selected | i_external_clock_selected) & ~i_timer2_async_select;
      // Pins C4/C5: two-wire, open drain
      pullup_override_en[`PIN_C4] = i_twowire_enable_bit;
      pullup_override_val[`PIN_C4] = pullup_if_input(i_port_out_c[4]);
      direction_override_en[`PIN_C4] = i_twowire_enable_bit;
      direction_override_val[`PIN_C4] = i_twowire_sda_drive_low;
      port_value_override_en[`PIN_C4] = i_twowire_enable_bit;
      pullup_override_en[`PIN_C5] = i_twowire_enable_bit;
      pullup_override_val[`PIN_C5] = pullup_if_input(i_port_out_c[5]);
      direction_override_en[`PIN_C5] = i_twowire_enable_bit;
      direction_override_val[`PIN_C5] = i_twowire_scl_drive_low;
      port_value_override_en[`PIN_C5] = i_twowire_enable_bit;
      // Pin C6: reset
      pullup_override_en[`PIN_C6]  = rst_pin;
      pullup_override_val[`PIN_C6]  = 1'b1;
      direction_override_en[`PIN_C6]  = rst_pin;
      input_enable_override_en[`PIN_C6] = rst_pin | input_enable_override_en[`PIN_C6];
      input_enable_override_val[`PIN_C6] = ~rst_pin;
   end

   // ************************************************
   // Per-pin selection
   // ************************************************
   for (genvar g = 0; g < 11; g++)
   begin : g_pin
      pin_override_cell u_cell
      (
         .i_port_out                  (port_out_all[g]),
         .i_port_dir                  (port_dir_all[g]),
         .i_pullup_disable            (i_global_pullup_disable),
         .i_sleeping                  (i_sleeping),
         .i_pullup_override_en        (pullup_override_en[g]),
         .i_pullup_override_val       (pullup_override_val[g]),
         .i_direction_override_en     (direction_override_en[g]),
         .i_direction_override_val    (direction_override_val[g]),
         .i_port_value_override_en    (port_value_override_en[g]),
         .i_port_value_override_val   (port_value_override_val[g]),
         .i_input_enable_override_en  (input_enable_override_en[g]),
         .i_input_enable_override_val (input_enable_override_val[g]),
         .o_pullup                    (pin_pullup[g]),
         .o_oe                        (pin_oe[g]),
         .o_out                       (pin_out[g]),
         .o_in_en                     (pin_in_en[g])
      );
   end

   // ************************************************
   // Pad synchronisers
   // ************************************************
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         sync1_q <= `PAD_SYNC_RST;
         sync2_q <= `PAD_SYNC_RST;
         sync3_q <= `PAD_SYNC_RST;
         stab_q  <= `PAD_SYNC_RST;
      end
      else
      begin
         sync1_q <= pad_all;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         stab_q  <= (sync2_q & ~(sync2_q ^ sync3_q)) | (stab_q & (sync2_q ^ sync3_q));
      end
   end

   // ************************************************
   // Two-wire spike filter
   // ************************************************
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         tw_q        <= `TW_RST;
         tw_cnt_q[0] <= '0;
         tw_cnt_q[1] <= '0;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (!i_twowire_enable_bit || stab_q[`PIN_C5 - i] == tw_q[i])
            begin
               tw_q[i]     <= stab_q[`PIN_C5 - i];
               tw_cnt_q[i] <= '0;
            end
            else if (tw_cnt_q[i] == spike_cnt_type'(`SPIKE_CYCLES - 1))
            begin
               tw_q[i]     <= stab_q[`PIN_C5 - i];
               tw_cnt_q[i] <= '0;
            end
            else
               tw_cnt_q[i] <= tw_cnt_q[i] + 2'd1;
         end
      end
   end

   // ************************************************
   // Registered pad controls
   // ************************************************
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_pad_b_out    <= '0;
         o_pad_b_oe     <= '0;
         o_pad_b_pullup <= '0;
         o_pad_c_out    <= '0;
         o_pad_c_oe     <= '0;
         o_pad_c_pullup <= '0;
      end
      else
      begin
         o_pad_b_out    <= pin_out[7:1];
         o_pad_b_oe     <= pin_oe[7:1];
         o_pad_b_pullup <= pin_pullup[7:0];
         o_pad_c_out    <= pin_out[10:8];
         o_pad_c_oe     <= pin_oe[10:8];
         o_pad_c_pullup <= pin_pullup[10:8];
      end
   end

   // Pin 0 keeps running through reset so the clock fuse still drives it
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n && !i_clock_output_fuse)
      begin
         o_pad_b0_out <= `OUT_RST;
         o_pad_b0_oe  <= `OUT_RST;
      end
      else
      begin
         o_pad_b0_out <= pin_out[`PIN_B0];
         o_pad_b0_oe  <= pin_oe[`PIN_B0];
      end
   end

   // ************************************************
   // Readback and peripheral inputs
   // ************************************************
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_pin_in_b           <= '0;
         o_pin_in_c           <= '0;
         o_dir_read_c6        <= 1'b0;
         o_out_read_c6        <= 1'b0;
         o_timer1_capture_in  <= 1'b1;
         o_spi_slave_select_n <= 1'b1;
         o_spi_slave_active   <= 1'b0;
         o_spi_master_data_in <= 1'b1;
         o_spi_slave_data_in  <= 1'b1;
         o_spi_sck_in         <= 1'b1;
         o_twowire_scl_in     <= 1'b1;
         o_twowire_sda_in     <= 1'b1;
         o_ext_reset_n        <= 1'b1;
      end
      else
      begin
         o_pin_in_b           <= stab_q[7:0] & pin_in_en[7:0] & {~osc_out_own, ~osc_in_own, 6'h3F};
         o_pin_in_c           <= stab_q[10:8] & pin_in_en[10:8] & {~rst_pin, 2'h3};
         o_dir_read_c6        <= i_port_dir_c[6] & ~rst_pin;
         o_out_read_c6        <= i_port_out_c[6] & ~rst_pin;
         o_timer1_capture_in  <= stab_q[`PIN_B0];
         o_spi_slave_select_n <= stab_q[`PIN_B2];
         o_spi_slave_active   <= slave & ~stab_q[`PIN_B2];
         o_spi_master_data_in <= stab_q[`PIN_B4];
         o_spi_slave_data_in  <= stab_q[`PIN_B3];
         o_spi_sck_in         <= stab_q[`PIN_B5];
         o_twowire_scl_in     <= tw_q[0];
         o_twowire_sda_in     <= tw_q[1];
         o_ext_reset_n        <= ~rst_pin | stab_q[`PIN_C6];
      end
   end

   // ************************************************
   // Assertions
   // ************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   property p_ss_input;
      slave |=> !o_pad_b_oe[2];
   endproperty
   a_ss_input: assert property (p_ss_input) else $error("slave select not forced input");

   property p_ss_active;
      (slave && !stab_q[`PIN_B2]) |=> o_spi_slave_active;
   endproperty
   a_ss_active: assert property (p_ss_active) else $error("slave not active on select low");

   property p_ss_master_dir;
      master |=> o_pad_b_oe[2] == $past(i_port_dir_b[2]);
   endproperty
   a_ss_master_dir: assert property (p_ss_master_dir) else $error("master select dir wrong");

   property p_ss_pullup;
      slave |=> o_pad_b_pullup[2] == $past(i_port_out_b[2] & ~i_global_pullup_disable);
   endproperty
   a_ss_pullup: assert property (p_ss_pullup) else $error("forced input pull-up wrong");

   property p_cmp_b;
      i_timer1_compare_b_en |=> o_pad_b_out[2] == $past(i_timer1_compare_b_out);
   endproperty
   a_cmp_b: assert property (p_cmp_b) else $error("compare B not on pin");

   property p_cmp_a;
      i_timer1_compare_a_en |=> o_pad_b_out[1] == $past(i_timer1_compare_a_out)
                                && o_pad_b_oe[1] == $past(i_port_dir_b[1]);
   endproperty
   a_cmp_a: assert property (p_cmp_a) else $error("compare A not on pin");

   property p_clk_out;
      disable iff (1'b0)
      i_clock_output_fuse |=> o_pad_b0_oe && o_pad_b0_out == $past(i_divided_sysclk_out);
   endproperty
   a_clk_out: assert property (p_clk_out) else $error("divided clock not driven");

   property p_scl_open_drain;
      i_twowire_enable_bit |=> !o_pad_c_out[5] && o_pad_c_oe[5] == $past(i_twowire_scl_drive_low);
   endproperty
   a_scl_open_drain: assert property (p_scl_open_drain) else $error("clock pin not open drain");

   property p_rst_readback;
      rst_pin |=> o_pin_in_c[6] == 1'b0 && !o_dir_read_c6 && !o_out_read_c6;
   endproperty
   a_rst_readback: assert property (p_rst_readback) else $error("reset pin readback not zero");

   property p_spike;
      (i_twowire_enable_bit && $past(i_twowire_enable_bit) && $changed(tw_q[1]))
         |-> $past(stab_q[`PIN_C4], 1) == tw_q[1] && $past(stab_q[`PIN_C4], 2) == tw_q[1];
   endproperty
   a_spike: assert property (p_spike) else $error("data spike passed filter");

   property p_pc_sleep;
      (i_pin_change_mask_b[3] && i_pin_change_group0_enable && i_sleeping)
         |=> o_pin_in_b[3] == $past(stab_q[`PIN_B3]);
   endproperty
   a_pc_sleep: assert property (p_pc_sleep) else $error("pin change input not enabled");

   c_slave_select: cover property (slave && !stab_q[`PIN_B2] ##1 o_spi_slave_active);
   c_clk_reset:    cover property (disable iff (1'b0) i_clock_output_fuse && !i_reset_n);
   c_tw_edge:      cover property (i_twowire_enable_bit && $changed(tw_q[0]));
endmodule
`default_nettype wire

/* verif/pad_world.sv */
// Board model: pads with board pull-ups and optional outside drivers.
// Assumes pad controls come registered from the override block.
`timescale 1ns/100ps
`default_nettype none
module pad_world
(
   // Pad controls and outside drive
   input  wire logic [7:0] i_oe,
   input  wire logic [7:0] i_out,
   input  wire logic [7:0] i_ext_en,
   input  wire logic [7:0] i_ext,
   // Resolved levels
   output logic      [7:0] o_pad
);
   // Released lines rise through the board pull-ups
   assign o_pad = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext) | (~i_oe & ~i_ext_en);
endmodule
`default_nettype wire

/* verif/port_alternate_function_override_tb.sv */
// Bench for the port override block: pad drive, readback, reset.
// Assumes the override block and pad_world are compiled first.
`timescale 1ns/100ps
`default_nettype none
module port_alternate_function_override_tb;
   import pin_override_pkg::*;
   logic i_clk = 0, i_reset_n = 0, i_global_pullup_disable = 0, i_sleeping = 0, i_spi_sck_out = 0;
   logic i_serial_periph_enable_bit = 0, i_serial_periph_master_sel = 0, i_spi_master_data_out = 0;
   logic i_spi_slave_data_out = 0, i_timer1_compare_a_en = 0, i_timer1_compare_a_out = 0;
   logic i_timer1_compare_b_en = 0, i_timer1_compare_b_out = 0, i_timer2_compare_a_en = 0;
   logic i_timer2_compare_a_out = 0, i_clock_output_fuse = 1, i_divided_sysclk_out = 1;
   logic i_internal_rc_selected = 1, i_external_clock_selected = 0, i_timer2_async_select = 0;
   logic i_reset_pin_disable_fuse = 0, i_twowire_enable_bit = 0, i_twowire_scl_drive_low = 0;
   logic i_twowire_sda_drive_low = 0, i_pin_change_group0_enable = 0, i_pin_change_group1_enable = 0;
   port_b_type i_port_out_b = '0, i_port_dir_b = '0, i_pin_change_mask_b = '0, o_pad_b_pullup, o_pin_in_b;
   port_c_type i_port_out_c = '0, i_port_dir_c = '0, i_pin_change_mask_c = '0;
   port_c_type o_pad_c_out, o_pad_c_oe, o_pad_c_pullup, o_pin_in_c;
   port_c_type i_pad_c = 3'b111;
   wire logic [7:0] i_pad_b;
   logic [7:0] ext_en = '0, ext = '0;
   logic [7:1] o_pad_b_out, o_pad_b_oe;
   logic o_pad_b0_out, o_pad_b0_oe, o_dir_read_c6, o_out_read_c6, o_timer1_capture_in, o_spi_slave_select_n;
   logic o_spi_slave_active, o_spi_master_data_in, o_spi_slave_data_in, o_spi_sck_in;
   logic o_twowire_scl_in, o_twowire_sda_in, o_ext_reset_n;
   int err_total = 0, comparisons = 0;
   port_alternate_function_override uut (.*);
   pad_world board (.i_oe({o_pad_b_oe, o_pad_b0_oe}), .i_out({o_pad_b_out, o_pad_b0_out}),
      .i_ext_en(ext_en), .i_ext(ext), .o_pad(i_pad_b));
   always #20 i_clk = ~i_clk;
   task automatic chk(input logic got, input logic exp);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH at %0t: got %b expected %b", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      step(10);
      chk(o_pad_b0_oe, 1);
      chk(o_pad_b0_out, 1);
      step(6);
      i_reset_n = 1;
      i_port_dir_b = 8'h06;
      i_port_out_b = 8'h04;
      i_timer1_compare_a_en = 1;
      i_timer1_compare_a_out = 1;
      step(1);
      chk(o_pad_b_out[1], 1);
      chk(o_pad_b_oe[1], 1);
      i_serial_periph_enable_bit = 1;
      ext_en = 8'h04;
      step(6);
      chk(o_pad_b_oe[2], 0);
      chk(o_pad_b_pullup[2], 1);
      chk(o_spi_slave_active, 1);
      chk(o_spi_slave_select_n, 0);
      chk(o_spi_slave_data_in, 1);
      i_twowire_enable_bit = 1;
      i_twowire_scl_drive_low = 1;
      i_port_dir_c = 3'b111;
      i_port_out_c = 3'b111;
      step(1);
      chk(o_pad_c_oe[5], 1);
      chk(o_pad_c_out[5], 0);
      chk(o_pad_c_pullup[5], 1);
      chk(o_dir_read_c6, 0);
      chk(o_out_read_c6, 0);
      chk(o_pin_in_c[6], 0);
      chk(o_ext_reset_n, 1);
      // One-cycle dip on both two-wire pads must not get through
      i_pad_c = 3'b100;
      step(1);
      i_pad_c = 3'b111;
      step(8);
      chk(o_twowire_scl_in, 1);
      chk(o_twowire_sda_in, 1);
      i_pad_c = 3'b100;
      step(6);
      chk(o_twowire_scl_in, 1);
      step(1);
      chk(o_twowire_scl_in, 0);
      chk(o_twowire_sda_in, 0);
      // Reset pin pulled low, then handed back as plain I/O
      i_pad_c = 3'b000;
      step(5);
      chk(o_ext_reset_n, 0);
      i_reset_pin_disable_fuse = 1;
      i_pad_c = 3'b111;
      step(5);
      chk(o_ext_reset_n, 1);
      chk(o_pin_in_c[6], 1);
      chk(o_dir_read_c6, 1);
      // Oscillator pins taken over by clock selection
      i_port_out_b = 8'hC4;
      step(1);
      chk(o_pad_b_pullup[7], 1);
      chk(o_pin_in_b[6], 1);
      i_internal_rc_selected = 0;
      step(1);
      chk(o_pad_b_pullup[6], 0);
      chk(o_pin_in_b[6], 0);
      chk(o_pad_b_pullup[7], 0);
      chk(o_pin_in_b[7], 0);
      i_external_clock_selected = 1;
      step(1);
      chk(o_pad_b_pullup[7], 1);
      chk(o_pin_in_b[7], 1);
      chk(o_pad_b_pullup[6], 0);
      // Sleep gates inputs unless pin change keeps them on
      i_sleeping = 1;
      step(1);
      chk(o_pin_in_b[3], 0);
      i_pin_change_mask_b = 8'h08;
      i_pin_change_group0_enable = 1;
      step(1);
      chk(o_pin_in_b[3], 1);
      // Master mode, compare B, clock output off
      chk(o_timer1_capture_in, 1);
      i_clock_output_fuse = 0;
      i_serial_periph_master_sel = 1;
      i_spi_master_data_out = 1;
      i_timer1_compare_b_en = 1;
      ext_en = 8'h15;
      step(1);
      chk(o_pad_b0_oe, 0);
      chk(o_pad_b_oe[2], 1);
      chk(o_pad_b_out[2], 0);
      chk(o_pad_b_out[3], 1);
      step(5);
      chk(o_timer1_capture_in, 0);
      chk(o_spi_master_data_in, 0);
      close_out();
   end
   initial
   begin
      #5000;
      err_total++;
      close_out();
   end
endmodule
`default_nettype wire
